//--- pfa_frame_sync.sv
// Frame timing unit: reference selection, frame slip and frame alignment.
// Assumes a 25 MHz clock, an AXI4-Lite master and asynchronous pins.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pfa_params.svh"
module pfa_frame_sync
    import pfa_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic normal_ref_clock,
    input wire logic fast_ref_clock,
    input wire logic ext_ref_clock,
    input wire logic normal_buffer_sync_n,
    input wire logic fast_buffer_sync_n,
    input wire logic serial_clock_in,
    input wire logic frame_sync_in,
    output logic pll_ref_clock,
    output logic buffer_sync_n,
    output logic frame_sync_out,
    output logic frame_slip,
    output pfa_pos_t rx_in_pos,
    output pfa_pos_t send_in_pos,
    output pfa_pos_t send_out_pos,
    output pfa_pos_t aux_pos
);

    localparam int FRAME_CYC = `PFA_FRAME_CYC;
    localparam int STEP_CYC = `PFA_SLIP_STEP_CYC;
    localparam int TARGET_CYC = `PFA_SLIP_TARGET_CYC;

    // Word index of a byte address, or 8'hff when misaligned.
    function automatic logic [7:0] word_index(input logic [7:0] addr);
        word_index = (addr[1:0] == 2'b00) ? {2'b00, addr[7:2]} : 8'hff;
    endfunction

    // Initial counter value from a frame offset and a phase offset.
    function automatic pfa_pos_t start_pos(input logic [7:0] ofs,
                                           input logic [1:0] ph);
        start_pos = {ofs, ph};
    endfunction

    // Registers.
    logic [6:0] slip_cfg_q;
    logic [7:0] rx_ofs_q;
    logic [7:0] si_ofs_q;
    logic [7:0] so_ofs_q;
    logic [7:0] aux_ofs_q;
    logic [7:0] phase_q;
    logic [3:0] ctrl_q;
    logic [7:0] slip_count_q;

    wire logic unlock = ctrl_q[`PFA_CTRL_UNLOCK_BIT];
    wire logic sample_rise = ctrl_q[`PFA_CTRL_EDGE_BIT];
    wire logic long_sync = ctrl_q[`PFA_CTRL_LEN_BIT];
    wire logic active_high = ctrl_q[`PFA_CTRL_POL_BIT];

    // Pin synchronisers: three stages, a change counts when two agree.
    localparam int NPIN = 7;
    // Idle pin levels, so that reset release shows no false edge.
    localparam logic [NPIN-1:0] PIN_IDLE = 7'h58;
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;
    logic [NPIN-1:0] pin_s3_q;
    logic [NPIN-1:0] pin_lvl_q;
    logic [NPIN-1:0] pin_prev_q;
    wire logic [NPIN-1:0] pin_raw = {frame_sync_in, serial_clock_in,
        fast_buffer_sync_n, normal_buffer_sync_n, ext_ref_clock,
        fast_ref_clock, normal_ref_clock};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= PIN_IDLE;
            pin_s2_q <= PIN_IDLE;
            pin_s3_q <= PIN_IDLE;
            pin_lvl_q <= PIN_IDLE;
            pin_prev_q <= PIN_IDLE;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_lvl_q <= (pin_s2_q & pin_s3_q) |
                         (pin_lvl_q & (pin_s2_q | pin_s3_q));
            pin_prev_q <= pin_lvl_q;
        end
    end

    wire logic sclk_rise = pin_lvl_q[5] & ~pin_prev_q[5];
    wire logic sclk_fall = ~pin_lvl_q[5] & pin_prev_q[5];
    wire logic fsi_lvl = pin_lvl_q[6];

    // Reference clock and buffer sync selection.
    logic sel_sync_n;
    always_comb begin
        sel_sync_n = slip_cfg_q[`PFA_SLIP_NF_BIT] ? pin_lvl_q[3]
                                                   : pin_lvl_q[4];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pll_ref_clock <= 1'b0;
            buffer_sync_n <= 1'b1;
        end else begin
            if (slip_cfg_q[`PFA_SLIP_EXT_BIT]) begin
                pll_ref_clock <= pin_lvl_q[2];
            end else if (slip_cfg_q[`PFA_SLIP_NF_BIT]) begin
                pll_ref_clock <= pin_lvl_q[0];
            end else begin
                pll_ref_clock <= pin_lvl_q[1];
            end
            buffer_sync_n <= sel_sync_n;
        end
    end

    // Active edge of the selected (active low) buffer sync.
    logic bsync_prev_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bsync_prev_q <= 1'b1;
        end else begin
            bsync_prev_q <= sel_sync_n;
        end
    end
    wire logic bsync_pulse = bsync_prev_q & ~sel_sync_n;

    // Frame timer; its wrap starts a frame sync output pulse.
    logic [11:0] frame_tmr_q;
    logic [11:0] dist_after;
    logic [11:0] dist_before;
    logic [11:0] safety_cyc;
    logic slip_now;
    always_comb begin
        dist_after = frame_tmr_q;
        dist_before = 12'(FRAME_CYC) - frame_tmr_q;
        safety_cyc = 12'(slip_cfg_q[`PFA_SLIP_IV_MSB:0] * STEP_CYC);
        slip_now = bsync_pulse &&
                   (dist_after < safety_cyc || dist_before < safety_cyc);
    end
    wire logic frame_wrap = (frame_tmr_q == 12'(FRAME_CYC - 1));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_tmr_q <= '0;
        end else if (slip_now) begin
            frame_tmr_q <= 12'(FRAME_CYC - TARGET_CYC);
        end else if (frame_wrap) begin
            frame_tmr_q <= '0;
        end else begin
            frame_tmr_q <= frame_tmr_q + 12'h001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_slip <= 1'b0;
            slip_count_q <= '0;
        end else begin
            frame_slip <= slip_now;
            if (slip_now) begin
                slip_count_q <= slip_count_q + 8'h01;
            end
        end
    end

    // Frame sync output generator, driven on the non-sampling edge.
    pfa_fso_e fso_q;
    logic [1:0] fso_cnt_q;
    wire logic drive_edge = sample_rise ? sclk_fall : sclk_rise;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fso_q <= FSO_IDLE;
            fso_cnt_q <= '0;
        end else begin
            unique case (fso_q)
                FSO_IDLE: begin
                    if (frame_wrap) begin
                        fso_q <= FSO_WAIT;
                    end
                end
                FSO_WAIT: begin
                    if (drive_edge) begin
                        fso_q <= FSO_ACTIVE;
                        fso_cnt_q <= long_sync ? 2'd2 : 2'd1;
                    end
                end
                FSO_ACTIVE: begin
                    if (drive_edge) begin
                        if (fso_cnt_q == 2'd1) begin
                            fso_q <= FSO_IDLE;
                        end
                        fso_cnt_q <= fso_cnt_q - 2'd1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_sync_out <= 1'b1;
        end else begin
            frame_sync_out <= (fso_q == FSO_ACTIVE) ~^ active_high;
        end
    end

    // Frame sync detection on the chosen serial clock edge.
    logic fsi_smp_q;
    logic det_pend_q;
    wire logic smp_edge = sample_rise ? sclk_rise : sclk_fall;
    wire logic fsi_active = fsi_lvl ~^ active_high;
    wire logic sync_det = smp_edge & fsi_active & ~fsi_smp_q;
    wire logic load_pos = sclk_fall & (sync_det | det_pend_q);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fsi_smp_q <= 1'b0;
            det_pend_q <= 1'b0;
        end else begin
            if (smp_edge) begin
                fsi_smp_q <= fsi_active;
            end
            if (sync_det && !sclk_fall) begin
                det_pend_q <= 1'b1;
            end else if (sclk_fall) begin
                det_pend_q <= 1'b0;
            end
        end
    end

    // Frame position counters of the four frames.
    pfa_frame_counter u_rx_in (
        .clock(clock),
        .rst_n(rst_n),
        .advance(sclk_fall),
        .load(load_pos),
        .load_val(start_pos(rx_ofs_q,
            phase_q[`PFA_PH_RX_LSB +: 2])),
        .pos_q(rx_in_pos)
    );
    pfa_frame_counter u_send_in (
        .clock(clock),
        .rst_n(rst_n),
        .advance(sclk_fall),
        .load(load_pos),
        .load_val(start_pos(si_ofs_q,
            phase_q[`PFA_PH_SI_LSB +: 2])),
        .pos_q(send_in_pos)
    );
    pfa_frame_counter u_send_out (
        .clock(clock),
        .rst_n(rst_n),
        .advance(sclk_fall),
        .load(load_pos),
        .load_val(start_pos(so_ofs_q,
            phase_q[`PFA_PH_SO_LSB +: 2])),
        .pos_q(send_out_pos)
    );
    pfa_frame_counter u_aux (
        .clock(clock),
        .rst_n(rst_n),
        .advance(sclk_fall),
        .load(load_pos),
        .load_val(start_pos(aux_ofs_q,
            phase_q[`PFA_PH_AUX_LSB +: 2])),
        .pos_q(aux_pos)
    );

    // AXI4-Lite write channel.
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_idx_q;
    logic [7:0] wbyte_q;
    logic [3:0] wnib_q;
    logic wlane_q;
    logic wr_go;
    logic wr_ok;
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;

    always_comb begin
        wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
        unique case (aw_idx_q)
            `PFA_IDX_SLIP_CFG, `PFA_IDX_RX_IN_OFS, `PFA_IDX_SEND_IN_OFS,
            `PFA_IDX_SEND_OUT_OFS, `PFA_IDX_AUX_OFS, `PFA_IDX_PHASE_OFS:
                wr_ok = unlock;
            `PFA_IDX_CTRL: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= '0;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PFA_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_idx_q <= word_index(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wbyte_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `PFA_RESP_OKAY : `PFA_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign wnib_q = wbyte_q[3:0];

    // Register writes; only lane 0 carries data.
    wire logic wr_en = wr_go && wr_ok && wlane_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slip_cfg_q <= `PFA_RST_SLIP_CFG;
            rx_ofs_q <= `PFA_RST_OFS;
            si_ofs_q <= `PFA_RST_OFS;
            so_ofs_q <= `PFA_RST_OFS;
            aux_ofs_q <= `PFA_RST_OFS;
            phase_q <= `PFA_RST_OFS;
            ctrl_q <= `PFA_RST_CTRL;
        end else if (wr_en) begin
            unique case (aw_idx_q)
                `PFA_IDX_SLIP_CFG: slip_cfg_q <= wbyte_q[6:0];
                `PFA_IDX_RX_IN_OFS: rx_ofs_q <= wbyte_q;
                `PFA_IDX_SEND_IN_OFS: si_ofs_q <= wbyte_q;
                `PFA_IDX_SEND_OUT_OFS: so_ofs_q <= wbyte_q;
                `PFA_IDX_AUX_OFS: aux_ofs_q <= wbyte_q;
                `PFA_IDX_PHASE_OFS: phase_q <= wbyte_q;
                `PFA_IDX_CTRL: ctrl_q <= wnib_q;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // AXI4-Lite read channel; answers one cycle after the address.
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        rd_word = '0;
        unique case (word_index(s_axi_araddr))
            `PFA_IDX_SLIP_CFG: rd_word = {25'h0, slip_cfg_q};
            `PFA_IDX_RX_IN_OFS: rd_word = {24'h0, rx_ofs_q};
            `PFA_IDX_SEND_IN_OFS: rd_word = {24'h0, si_ofs_q};
            `PFA_IDX_SEND_OUT_OFS: rd_word = {24'h0, so_ofs_q};
            `PFA_IDX_AUX_OFS: rd_word = {24'h0, aux_ofs_q};
            `PFA_IDX_PHASE_OFS: rd_word = {24'h0, phase_q};
            `PFA_IDX_CTRL: rd_word = {28'h0, ctrl_q};
            `PFA_IDX_STATUS: rd_word = {12'h0, fsi_lvl,
                fso_q == FSO_ACTIVE, rx_in_pos, slip_count_q};
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `PFA_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `PFA_RESP_OKAY : `PFA_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // pfa_frame_sync

//--- pfa_params.svh
// Constants of the frame alignment and sync unit.
// Assumes a 25 MHz system clock and 32-bit AXI4-Lite register access.
`ifndef PFA_PARAMS_SVH
`define PFA_PARAMS_SVH

// Register indices; byte address is four times the index.
`define PFA_IDX_SLIP_CFG 8'h0c
`define PFA_IDX_RX_IN_OFS 8'h0d
`define PFA_IDX_SEND_IN_OFS 8'h0e
`define PFA_IDX_SEND_OUT_OFS 8'h0f
`define PFA_IDX_AUX_OFS 8'h10
`define PFA_IDX_PHASE_OFS 8'h11
`define PFA_IDX_CTRL 8'h12
`define PFA_IDX_STATUS 8'h13

// Field positions of frame_slip_config.
`define PFA_SLIP_IV_MSB 4
`define PFA_SLIP_NF_BIT 5
`define PFA_SLIP_EXT_BIT 6

// Field positions of bit_phase_offsets.
`define PFA_PH_RX_LSB 0
`define PFA_PH_SI_LSB 2
`define PFA_PH_SO_LSB 4
`define PFA_PH_AUX_LSB 6

// Field positions of the control register.
`define PFA_CTRL_UNLOCK_BIT 0
`define PFA_CTRL_EDGE_BIT 1
`define PFA_CTRL_LEN_BIT 2
`define PFA_CTRL_POL_BIT 3

// Reset values.
`define PFA_RST_SLIP_CFG 7'h28
`define PFA_RST_OFS 8'h00
`define PFA_RST_CTRL 4'h0

// Timing, in nanoseconds, and derived counts of system clock cycles.
`define PFA_CLK_NS 40
`define PFA_FRAME_NS 125000
`define PFA_SLIP_STEP_NS 2000
`define PFA_SLIP_TARGET_NS 62500
`define PFA_FRAME_CYC (`PFA_FRAME_NS / `PFA_CLK_NS)
`define PFA_SLIP_STEP_CYC (`PFA_SLIP_STEP_NS / `PFA_CLK_NS)
`define PFA_SLIP_TARGET_CYC (`PFA_SLIP_TARGET_NS / `PFA_CLK_NS)

// AXI responses.
`define PFA_RESP_OKAY 2'b00
`define PFA_RESP_SLVERR 2'b10

`endif

//--- pfa_pkg.sv
// Types shared by the frame alignment and sync unit.
// Assumes nothing beyond a SystemVerilog compiler.
package pfa_pkg;

    // Frame position: {channel[4:0], bit slot[2:0], phase[1:0]}.
    typedef logic [9:0] pfa_pos_t;

    // States of the frame sync output generator.
    typedef enum logic [1:0] {
        FSO_IDLE,
        FSO_WAIT,
        FSO_ACTIVE
    } pfa_fso_e;

endpackage

//--- pfa_frame_counter.sv
// Frame position counter of one serial frame.
// Assumes load and advance are one-cycle pulses of the system clock.
`timescale 1ns/1ps
module pfa_frame_counter
    import pfa_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic advance,
    input wire logic load,
    input wire pfa_pos_t load_val,
    output pfa_pos_t pos_q
);

    // Loads on detected frame sync, else steps one phase per serial clock.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= '0;
        end else if (load) begin
            pos_q <= load_val;
        end else if (advance) begin
            pos_q <= pos_q + 10'h001;
        end
    end

endmodule // pfa_frame_counter

//--- pfa_frame_sync_checker.sv
// Concurrent checks on the ports of the frame timing unit.
// Assumes it is bound onto pfa_frame_sync with matching port names.
`timescale 1ns/1ps
`include "pfa_params.svh"
module pfa_frame_sync_checker
    import pfa_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_sync_out,
    input wire logic frame_slip,
    input wire pfa_pos_t rx_in_pos
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped early.");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped early.");
    a_wr_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("Write accepted while response pending.");
    a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read accepted while data pending.");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("Read answer late.");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("Write answer late.");
    a_slip_pulse: assert property (frame_slip |=> !frame_slip)
        else $error("Slip pulse longer than one cycle.");
    a_sync_len: assert property ($changed(frame_sync_out)
        |=> $stable(frame_sync_out) [*6])
        else $error("Sync output level shorter than a serial clock.");
    a_pos_step: assert property ($changed(rx_in_pos)
        |=> $stable(rx_in_pos) [*6])
        else $error("Position moved twice in a serial clock.");

    c_slip: cover property (frame_slip);
    c_wr_err: cover property (s_axi_bvalid
        && s_axi_bresp == `PFA_RESP_SLVERR);
    c_rd_ok: cover property (s_axi_rvalid && s_axi_rresp == `PFA_RESP_OKAY);
endmodule // pfa_frame_sync_checker

//--- pfa_link_model.sv
// Far side: serial clock, frame sync, reference clocks and buffer sync.
// Assumes the bench pulses fs_req and bs_req for one system clock.
`timescale 1ns/1ps
module pfa_link_model (
    input wire logic fs_req,
    input wire logic bs_req,
    output logic serial_clock_in,
    output logic frame_sync_in,
    output logic normal_ref_clock,
    output logic fast_ref_clock,
    output logic ext_ref_clock,
    output logic normal_buffer_sync_n,
    output logic fast_buffer_sync_n
);
    initial begin
        frame_sync_in = 1'h1;
        normal_buffer_sync_n = 1'h1;
        fast_buffer_sync_n = 1'h1;
        normal_ref_clock = 1'h0;
        fast_ref_clock = 1'h0;
        ext_ref_clock = 1'h0;
        serial_clock_in = 1'h0;
        #7;
        forever #160 serial_clock_in = ~serial_clock_in;
    end
    always #200 normal_ref_clock = ~normal_ref_clock;
    always #120 fast_ref_clock = ~fast_ref_clock;
    always #280 ext_ref_clock = ~ext_ref_clock;
    // Active-low sync for one serial clock, changed on the rising edge.
    always @(posedge fs_req) begin
        @(posedge serial_clock_in) frame_sync_in = 1'h0;
        @(posedge serial_clock_in) frame_sync_in = 1'h1;
    end
    always @(posedge bs_req) begin
        normal_buffer_sync_n = 1'h0;
        #400 normal_buffer_sync_n = 1'h1;
    end
endmodule // pfa_link_model

//--- pfa_frame_sync_tb_top.sv
// Bench of the frame timing unit: registers, alignment, reference, slip.
// Assumes the link model drives the pins and the checker is bound below.
`timescale 1ns/1ps
`include "pfa_params.svh"
module pfa_frame_sync_tb_top
    import pfa_pkg::*;
;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic normal_ref_clock, fast_ref_clock, ext_ref_clock, serial_clock_in;
    logic normal_buffer_sync_n, fast_buffer_sync_n, frame_sync_in;
    logic pll_ref_clock, buffer_sync_n, frame_sync_out, frame_slip;
    pfa_pos_t rx_in_pos, send_in_pos, send_out_pos, aux_pos;
    logic fs_req = 1'h0, bs_req = 1'h0, slip_seen = 1'h0;
    int n_errors = 0, tests_run = 0;
    logic [7:0] ra [6] = '{8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44};
    logic [7:0] rv [6] = '{8'h2c, 8'ha5, 8'h3c, 8'hff, 8'h12, 8'he4};

    pfa_frame_sync dut_u (.*);
    pfa_link_model link_u (.*);

    always #20 clock = ~clock;

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d.", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 64);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n >= 64) check("write_wait", n, 0);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 64);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n >= 64) check("read_wait", n, 0);
    endtask

    task automatic ref_win(input logic [7:0] cfg, input int ne,
                           input logic ebs);
        logic [1:0] r;
        logic pr;
        logic bmin;
        int e;
        axi_wr(8'h30, {24'h0, cfg}, r);
        repeat (8) @(posedge clock);
        e = 0;
        bmin = 1'h1;
        pr = pll_ref_clock;
        bs_req <= 1'h1;
        repeat (140) begin
            @(posedge clock);
            bs_req <= 1'h0;
            if (pll_ref_clock === 1'h1 && pr === 1'h0) e++;
            pr = pll_ref_clock;
            bmin = bmin & buffer_sync_n;
        end
        check("ref_edges_ok", e >= ne - 1 && e <= ne + 1, 1'h1);
        check("buffer_sync_n", bmin, ebs);
    endtask

    task automatic to_sync(output int n);
        logic p;
        n = 0;
        p = frame_sync_out;
        forever begin
            @(posedge clock);
            bs_req <= 1'h0;
            n++;
            slip_seen = slip_seen | frame_slip;
            if ((p === 1'h1 && frame_sync_out === 1'h0) || n > 4000) break;
            p = frame_sync_out;
        end
    endtask

    task automatic len_of(output int n);
        n = 0;
        while (frame_sync_out === 1'h0 && n < 40) begin
            @(posedge clock);
            n++;
        end
    endtask

    initial begin
        #(40 * 60000);
        check("watchdog", 0, 1);
        finish_test();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            axi_rd(ra[i], d, r);
            check("reset_value", d, (i == 0) ? 32'h28 : 32'h0);
        end
        axi_wr(8'h30, 32'h7f, r);
        check("locked_bresp", r, `PFA_RESP_SLVERR);
        axi_rd(8'h30, d, r);
        check("locked_value", d, 32'h28);
        axi_rd(8'h80, d, r);
        check("unmapped_rresp", r, `PFA_RESP_SLVERR);
        check("unmapped_rdata", d, 32'h0);
        axi_wr(8'h48, 32'h1, r);
        for (int i = 0; i < 6; i++) begin
            axi_wr(ra[i], {24'h0, rv[i]}, r);
            axi_rd(ra[i], d, r);
            check("reg_value", d, {24'h0, rv[i]});
        end
        $display("Test registers done.");
        fs_req <= 1'h1;
        @(posedge clock);
        fs_req <= 1'h0;
        n = 0;
        while (rx_in_pos !== 10'h294 && n < 300) begin
            @(posedge clock);
            n++;
        end
        check("rx_in_pos", rx_in_pos, 10'h294);
        check("send_in_pos", send_in_pos, 10'h0f1);
        check("send_out_pos", send_out_pos, 10'h3fe);
        check("aux_pos", aux_pos, 10'h04b);
        repeat (10) @(posedge clock);
        check("rx_in_pos_next", rx_in_pos, 10'h295);
        $display("Test alignment done.");
        ref_win(8'h6c, 10, 1'h0);
        ref_win(8'h2c, 14, 1'h0);
        ref_win(8'h0c, 23, 1'h1);
        axi_wr(8'h30, 32'h2c, r);
        $display("Test reference select done.");
        to_sync(n);
        len_of(n);
        check("sync_len_one", n >= 7 && n <= 9, 1'h1);
        repeat (500 - n) @(posedge clock);
        slip_seen = 1'h0;
        bs_req <= 1'h1;
        to_sync(n);
        check("slip_done", slip_seen, 1'h1);
        check("slip_spacing", n >= 1562 && n <= 1582, 1'h1);
        len_of(n);
        repeat (700 - n) @(posedge clock);
        slip_seen = 1'h0;
        bs_req <= 1'h1;
        to_sync(n);
        check("no_slip", slip_seen, 1'h0);
        check("frame_spacing", n >= 2410 && n <= 2440, 1'h1);
        axi_wr(8'h48, 32'h5, r);
        to_sync(n);
        len_of(n);
        check("sync_len_two", n >= 15 && n <= 17, 1'h1);
        axi_wr(8'h48, 32'hd, r);
        repeat (4) @(posedge clock);
        check("sync_idle_level", frame_sync_out, 1'h0);
        $display("Test slip and sync output done.");
        finish_test();
    end
endmodule // pfa_frame_sync_tb_top

bind pfa_frame_sync pfa_frame_sync_checker chk_u (.*);
